// File: core/tc_pkg.sv
package tc_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int CW = 16;
  localparam logic [15:0] MODE_RESET = 16'h0800;
  localparam logic [15:0] LOAD_RESET = 16'h0000;
  localparam logic [15:0] HOLD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // mode register field positions
  // ----------------------------------------------------------------
  localparam int M_DIR = 3;
  localparam int M_BCD = 4;
  localparam int M_REPEAT = 5;
  localparam int M_RELOAD = 6;
  localparam int M_SPECIAL = 7;
  localparam int M_SRC_LO = 8;
  localparam int M_SRC_HI = 11;
  localparam int M_POL = 12;
  localparam int M_GATE_LO = 13;
  localparam int M_GATE_HI = 15;

  // ----------------------------------------------------------------
  // gating field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] G_NONE = 3'h0;
  localparam logic [2:0] G_LOWER_TC = 3'h1;
  localparam logic [2:0] G_NEXT_HI = 3'h2;
  localparam logic [2:0] G_NEXT_LO = 3'h3;
  localparam logic [2:0] G_OWN_HIGH = 3'h4;
  localparam logic [2:0] G_OWN_LOW = 3'h5;
  localparam logic [2:0] G_EDGE_RISE = 3'h6;
  localparam logic [2:0] G_EDGE_FALL = 3'h7;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_LOAD = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;

  // ----------------------------------------------------------------
  // command register bits (write one to act)
  // ----------------------------------------------------------------
  localparam int C_LOAD = 0;
  localparam int C_ARM = 1;
  localparam int C_LOAD_ARM = 2;
  localparam int C_STEP = 3;
  localparam int C_DISARM = 4;
  localparam int C_SET_TOG = 5;
  localparam int C_CLR_TOG = 6;

  // ----------------------------------------------------------------
  // status register bits
  // ----------------------------------------------------------------
  localparam int S_ARMED = 0;
  localparam int S_TC = 1;
  localparam int S_TOGGLE = 2;
  localparam int S_RETRIG = 3;
  localparam int S_EDGE_RUN = 4;

  // ----------------------------------------------------------------
  // synchroniser layout: 16 count sources then 5 gate pins
  // ----------------------------------------------------------------
  localparam int NSRC = 16;
  localparam int NSYNC = 21;

endpackage : tc_pkg

// File: core/counter_tc_gating_control.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module counter_tc_gating_control #(
  parameter int COUNTER_ID = 1
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count and gate inputs
  input wire logic [4:0] freq_in,
  input wire logic [4:0] count_input_pin,
  input wire logic [4:0] gate_pin,
  input wire logic lower_counter_terminal_pulse,
  // counter outputs
  output logic terminal_count,
  output logic tc_toggle_out,
  output logic armed_out
);

  localparam int OWN_IDX = COUNTER_ID - 1;
  localparam int HI_IDX = COUNTER_ID % 5;
  localparam int LO_IDX = (COUNTER_ID + 3) % 5;

  // ----------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------
  logic [15:0] mode_reg, load_reg, hold_reg, counter_reg, counter_next;
  logic tc_reg, toggle_reg, armed_reg, retrig_reg, alt_reg, seen_reg;
  logic disarm_pend_reg, edge_run_reg, gate_lvl_prev_reg;
  logic [31:0] prdata_reg;
  logic [tc_pkg::NSYNC-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [tc_pkg::NSYNC-1:0] raw_in;

  // decoded controls
  logic up, bcd, repeat_on, reload_sel, special, pol;
  logic [2:0] gating;
  logic [3:0] src_code;
  logic edge_mode, no_gating, retrig_en, double_tc;
  // events
  logic wr_acc, cmd_wr, load_cmd, arm_cmd, step_cmd, disarm_cmd;
  logic src_edge, gate_lvl, gate_on, own_edge, gate_trig, retrig_req;
  logic qual_edge, count_pulse, retrig_path, plain_load, at_one;
  logic tc_enter, tc_leave, cycle_done;
  logic [15:0] reload_val;

  // ----------------------------------------------------------------
  // counting arithmetic
  // ----------------------------------------------------------------
  // one step up or down, binary or four bcd digits
  function automatic logic [15:0] step_value(input logic [15:0] v, input logic u,
                                             input logic b);
    logic [15:0] r;
    logic carry;
    logic [3:0] d;
    r = 16'h0000;
    carry = 1'b1;
    if (!b) begin
      r = u ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
    end else begin
      for (int i = 0; i < 4; i++) begin
        d = v[i*4 +: 4];
        if (carry && u) begin
          carry = (d >= 4'h9);
          d = carry ? 4'h0 : 4'(d + 4'h1);
        end else if (carry) begin
          carry = (d == 4'h0);
          d = carry ? 4'h9 : 4'(d - 4'h1);
        end
        r[i*4 +: 4] = d;
      end
    end
    return r;
  endfunction : step_value

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // codes 8..12 are the divided frequencies so the preset selects the first
  assign raw_in = {gate_pin, gate_pin[4:2], freq_in, gate_pin[1:0], count_input_pin,
                   lower_counter_terminal_pulse};

  // two flops then one history flop; edges only compare stage two and three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // mode decode and event generation
  // ----------------------------------------------------------------
  always_comb begin
    up = mode_reg[tc_pkg::M_DIR];
    bcd = mode_reg[tc_pkg::M_BCD];
    repeat_on = mode_reg[tc_pkg::M_REPEAT];
    reload_sel = mode_reg[tc_pkg::M_RELOAD];
    special = mode_reg[tc_pkg::M_SPECIAL];
    pol = mode_reg[tc_pkg::M_POL];
    gating = mode_reg[tc_pkg::M_GATE_HI:tc_pkg::M_GATE_LO];
    src_code = mode_reg[tc_pkg::M_SRC_HI:tc_pkg::M_SRC_LO];
    no_gating = (gating == tc_pkg::G_NONE);
    edge_mode = (gating == tc_pkg::G_EDGE_RISE) || (gating == tc_pkg::G_EDGE_FALL);
    retrig_en = special && !no_gating;
    double_tc = reload_sel;
    // apb access phase
    wr_acc = psel && penable && pwrite && clk_en;
    cmd_wr = wr_acc && (paddr == tc_pkg::OFS_CMD);
    load_cmd = cmd_wr && (pwdata[tc_pkg::C_LOAD] || pwdata[tc_pkg::C_LOAD_ARM]);
    arm_cmd = cmd_wr && (pwdata[tc_pkg::C_ARM] || pwdata[tc_pkg::C_LOAD_ARM]);
    step_cmd = cmd_wr && pwdata[tc_pkg::C_STEP];
    disarm_cmd = cmd_wr && pwdata[tc_pkg::C_DISARM];
    // selected source edge with polarity
    src_edge = clk_en && (pol ? (prev_reg[src_code] && !sync2_reg[src_code])
                              : (!prev_reg[src_code] && sync2_reg[src_code]));
    // level gate condition
    unique case (gating)
      tc_pkg::G_NONE: gate_lvl = 1'b1;
      tc_pkg::G_LOWER_TC: gate_lvl = sync2_reg[0];
      tc_pkg::G_NEXT_HI: gate_lvl = sync2_reg[tc_pkg::NSRC + HI_IDX];
      tc_pkg::G_NEXT_LO: gate_lvl = sync2_reg[tc_pkg::NSRC + LO_IDX];
      tc_pkg::G_OWN_HIGH: gate_lvl = sync2_reg[tc_pkg::NSRC + OWN_IDX];
      tc_pkg::G_OWN_LOW: gate_lvl = !sync2_reg[tc_pkg::NSRC + OWN_IDX];
      default: gate_lvl = 1'b0;
    endcase
    own_edge = clk_en && ((gating == tc_pkg::G_EDGE_RISE)
                          ? (!prev_reg[tc_pkg::NSRC + OWN_IDX] && sync2_reg[tc_pkg::NSRC + OWN_IDX])
                          : (prev_reg[tc_pkg::NSRC + OWN_IDX] && !sync2_reg[tc_pkg::NSRC + OWN_IDX]));
    gate_on = edge_mode ? edge_run_reg : gate_lvl;
    // active-going gate edge: level rise, or the start edge while armed
    gate_trig = edge_mode ? (own_edge && armed_reg)
                          : (clk_en && !no_gating && gate_lvl && !gate_lvl_prev_reg);
    retrig_req = retrig_en && gate_trig;
    qual_edge = src_edge && armed_reg && gate_on;
    at_one = up ? (counter_reg == (bcd ? 16'h9999 : 16'hFFFF)) : (counter_reg == 16'h0001);
    // a load turns into a pseudo count near terminal count or after retrigger; a step is always a count
    count_pulse = qual_edge || (src_edge && tc_reg) || step_cmd
                  || (load_cmd && (at_one || tc_reg || retrig_reg));
    retrig_path = count_pulse && retrig_reg && !tc_reg && !at_one;
    plain_load = load_cmd && !count_pulse;
    tc_enter = count_pulse && !retrig_path && at_one;
    tc_leave = count_pulse && tc_reg && !at_one;
    cycle_done = tc_enter && (!double_tc || seen_reg);
    // reload source choice
    if (no_gating && special) begin
      reload_val = sync2_reg[tc_pkg::NSRC + OWN_IDX] ? hold_reg : load_reg;
    end else if (reload_sel && no_gating) begin
      reload_val = sync2_reg[tc_pkg::NSRC + OWN_IDX] ? hold_reg : load_reg;
    end else if (reload_sel) begin
      reload_val = alt_reg ? hold_reg : load_reg;
    end else begin
      reload_val = load_reg;
    end
    // counter next value
    if (plain_load) begin
      counter_next = reload_val;
    end else if (retrig_path) begin
      counter_next = load_reg;
    end else if (tc_enter) begin
      counter_next = reload_val;
    end else if (count_pulse) begin
      counter_next = step_value(counter_reg, up, bcd);
    end else begin
      counter_next = counter_reg;
    end
  end

  // ----------------------------------------------------------------
  // counter and terminal count
  // ----------------------------------------------------------------
  // a boundary reload re-enters terminal count and keeps it high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= 16'h0000;
      tc_reg <= 1'b0;
    end else if (clk_en) begin
      counter_reg <= counter_next;
      if (tc_enter) begin
        tc_reg <= 1'b1;
      end else if (count_pulse) begin
        tc_reg <= 1'b0;
      end
    end
  end

  // toggle flips each time a count leaves or re-enters terminal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_reg <= 1'b0;
    end else if (clk_en) begin
      if (count_pulse && tc_reg) begin
        toggle_reg <= !toggle_reg;
      end else if (cmd_wr && pwdata[tc_pkg::C_SET_TOG]) begin
        toggle_reg <= 1'b1;
      end else if (cmd_wr && pwdata[tc_pkg::C_CLR_TOG]) begin
        toggle_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // arming, cycle tracking and gate state
  // ----------------------------------------------------------------
  // disarm never lands inside terminal count, so it cannot latch up there
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
      disarm_pend_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (arm_cmd) begin
        armed_reg <= 1'b1;
        disarm_pend_reg <= 1'b0;
        seen_reg <= 1'b0;
      end else begin
        if (tc_enter) begin
          seen_reg <= double_tc && !seen_reg;
        end
        if (disarm_cmd && !tc_reg && !tc_enter) begin
          armed_reg <= 1'b0;
        end else if (tc_leave && disarm_pend_reg) begin
          armed_reg <= 1'b0;
          disarm_pend_reg <= 1'b0;
        end else if ((cycle_done && !repeat_on) || (disarm_cmd && (tc_reg || tc_enter))) begin
          disarm_pend_reg <= 1'b1;
        end
      end
    end
  end

  // edge gating run flag, retrigger pending, alternation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_run_reg <= 1'b0;
      retrig_reg <= 1'b0;
      alt_reg <= 1'b1;
      gate_lvl_prev_reg <= 1'b0;
    end else if (clk_en) begin
      gate_lvl_prev_reg <= gate_lvl;
      if (edge_mode && own_edge && armed_reg) begin
        edge_run_reg <= 1'b1;
      end else if (cycle_done || !armed_reg) begin
        edge_run_reg <= 1'b0;
      end
      // a retrigger in the committed cycle does not delay terminal count
      if (retrig_req && !at_one && !tc_reg) begin
        retrig_reg <= 1'b1;
      end else if (retrig_path || !armed_reg) begin
        retrig_reg <= 1'b0;
      end
      if (arm_cmd) begin
        alt_reg <= 1'b1;
      end else if (tc_enter && reload_sel && !no_gating) begin
        alt_reg <= !alt_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // hardware hold capture beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= tc_pkg::MODE_RESET;
      load_reg <= tc_pkg::LOAD_RESET;
      hold_reg <= tc_pkg::HOLD_RESET;
    end else if (clk_en) begin
      if (wr_acc && paddr == tc_pkg::OFS_MODE) begin
        mode_reg <= pwdata[15:0];
      end
      if (wr_acc && paddr == tc_pkg::OFS_LOAD) begin
        load_reg <= pwdata[15:0];
      end
      if (retrig_req) begin
        hold_reg <= counter_reg;
      end else if (wr_acc && paddr == tc_pkg::OFS_HOLD) begin
        hold_reg <= pwdata[15:0];
      end
    end
  end

  // read data captured in the setup phase, valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (clk_en && psel && !penable) begin
      unique case (paddr)
        tc_pkg::OFS_MODE: prdata_reg <= {16'h0000, mode_reg};
        tc_pkg::OFS_LOAD: prdata_reg <= {16'h0000, load_reg};
        tc_pkg::OFS_HOLD: prdata_reg <= {16'h0000, hold_reg};
        tc_pkg::OFS_STATUS: prdata_reg <= {27'h0000000, edge_run_reg, retrig_reg,
                                           toggle_reg, tc_reg, armed_reg};
        tc_pkg::OFS_COUNT: prdata_reg <= {16'h0000, counter_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1; // never waits
  assign pslverr = psel && penable && !(paddr == tc_pkg::OFS_MODE || paddr == tc_pkg::OFS_LOAD
                   || paddr == tc_pkg::OFS_HOLD || paddr == tc_pkg::OFS_CMD
                   || paddr == tc_pkg::OFS_STATUS || paddr == tc_pkg::OFS_COUNT);
  assign terminal_count = tc_reg;
  assign tc_toggle_out = toggle_reg;
  assign armed_out = armed_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  commit_to_tc_a: assert property (tc_enter |=> tc_reg && counter_reg == $past(reload_val))
    else $error("count from boundary did not enter terminal count with reload");
  tc_one_period_a: assert property (tc_reg && src_edge && !at_one |=> !tc_reg)
    else $error("terminal count outlived a source edge");
  load_ends_tc_a: assert property (tc_reg && load_cmd && !at_one |=> !tc_reg)
    else $error("load during terminal count did not end it");
  toggle_flip_a: assert property (tc_reg && count_pulse |=> toggle_reg != $past(toggle_reg))
    else $error("toggle output missed a terminal count end");
  retrig_hold_a: assert property (retrig_req |=> hold_reg == $past(counter_reg))
    else $error("retrigger did not save count to hold");
  unqual_edge_a: assert property (src_edge && !armed_reg && !tc_reg && !cmd_wr
                                  |=> $stable(counter_reg))
    else $error("disarmed counter moved on a source edge");
  self_disarm_a: assert property (tc_leave && disarm_pend_reg && !arm_cmd |=> !armed_reg)
    else $error("counter did not disarm after its cycle");
  load_reload_a: assert property (tc_enter && !reload_sel && !special
                                  |=> counter_reg == $past(load_reg))
    else $error("reload did not come from load register");
  alt_first_hold_a: assert property (arm_cmd |=> alt_reg)
    else $error("arm did not reset alternation to hold");

  tc_enter_c: cover property (tc_enter);
  retrig_used_c: cover property (retrig_path);
  auto_disarm_c: cover property (tc_leave && disarm_pend_reg);
  tc_stay_c: cover property (tc_reg && count_pulse && at_one);

endmodule : counter_tc_gating_control

`default_nettype wire

// File: verification/tc_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// source and gate pins beside one counter
// ------------------------------------------------------------
module tc_pins_model (
  // clock
  input wire logic pclk,
  // pins seen by the counter
  output logic [4:0] freq_in,
  output logic [4:0] count_input_pin,
  output logic [4:0] gate_pin,
  output logic lower_counter_terminal_pulse
);
  logic [7:0] div_reg = 8'h00;
  // divided frequencies run free, each level held at least 8 cycles
  always @(posedge pclk) div_reg <= div_reg + 8'h01;
  assign freq_in = div_reg[7:3];
  initial begin
    count_input_pin = 5'h00;
    gate_pin = 5'h00;
    lower_counter_terminal_pulse = 1'b0;
  end
  // levels held 4 cycles so the synchroniser sees each edge once
  task automatic drive(input int i, input logic v);
    count_input_pin[i] <= v;
    repeat (4) @(posedge pclk);
  endtask : drive
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      drive(i, 1'b1);
      drive(i, 1'b0);
    end
  endtask : pulse
  task automatic gate(input int i, input logic v);
    gate_pin[i] <= v;
    repeat (4) @(posedge pclk);
  endtask : gate
endmodule : tc_pins_model
`default_nettype wire

// File: verification/counter_tc_gating_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module counter_tc_gating_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, terminal_count, tc_toggle_out, armed_out, lower_pulse;
  logic [4:0] freq_in, count_input_pin, gate_pin;
  logic [40:0] notes[$];
  logic [40:0] n;
  logic [15:0] l_val;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 32'hC31E;
  int i;
  counter_tc_gating_control #(.COUNTER_ID(1)) i_counter_tc_gating_control (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .freq_in(freq_in), .count_input_pin(count_input_pin),
    .gate_pin(gate_pin), .lower_counter_terminal_pulse(lower_pulse),
    .terminal_count(terminal_count), .tc_toggle_out(tc_toggle_out), .armed_out(armed_out));
  tc_pins_model i_tc_pins_model (.pclk(pclk), .freq_in(freq_in),
    .count_input_pin(count_input_pin), .gate_pin(gate_pin),
    .lower_counter_terminal_pulse(lower_pulse));
  // ------------------------------------------------------------
  // clock, verdict, apb master
  // ------------------------------------------------------------
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // a read notes its expected word; the monitor below judges it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) notes.push_back({a, e});
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      num_errors++;
      give_verdict();
    end else begin
      // one idle edge so a following call never re-raises psel in this time step
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  // command effects land on the write edge itself; two spare edges follow
  task automatic cmd(input int b);
    wr(tc_pkg::OFS_CMD, 32'h1 << b);
    repeat (2) @(posedge pclk);
  endtask : cmd
  function automatic logic [31:0] mw(input logic d, input logic b, input logic r,
                                     input logic [3:0] s, input logic p, input logic [2:0] g);
    mw = 32'h0;
    mw[tc_pkg::M_DIR] = d;
    mw[tc_pkg::M_BCD] = b;
    mw[tc_pkg::M_REPEAT] = r;
    mw[tc_pkg::M_SRC_HI:tc_pkg::M_SRC_LO] = s;
    mw[tc_pkg::M_POL] = p;
    mw[tc_pkg::M_GATE_HI:tc_pkg::M_GATE_LO] = g;
  endfunction : mw
  // monitor: zero wait states, so read data is judged at the access edge
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      total_checks++;
      if ({pslverr, prdata} !== n[32:0]) begin
        $display("FAIL reg %h exp %h got %h", n[40:33], n[32:0], {pslverr, prdata});
        num_errors++;
      end
      // status reads also judge the counter's output pins
      if (n[40:33] == tc_pkg::OFS_STATUS) begin
        total_checks++;
        if ({tc_toggle_out, terminal_count, armed_out} !== n[2:0]) begin
          $display("FAIL pins exp %h got %h", n[2:0], {tc_toggle_out, terminal_count, armed_out});
          num_errors++;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(tc_pkg::OFS_MODE, 32'h0800);
    rd(tc_pkg::OFS_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    // one-shot count from a random load value, self-disarm at the end
    l_val = 16'($unsigned($random(seed)) % 8 + 3);
    wr(tc_pkg::OFS_MODE, mw(0, 0, 0, 4'h1, 0, tc_pkg::G_NONE));
    wr(tc_pkg::OFS_LOAD, {16'h0, l_val});
    cmd(tc_pkg::C_LOAD_ARM);
    i_tc_pins_model.pulse(0, int'(l_val) - 1);
    rd(tc_pkg::OFS_COUNT, 32'h1);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_COUNT, {16'h0, l_val});
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_COUNT, {16'h0, l_val - 16'h1});
    i_tc_pins_model.pulse(0, 2);
    rd(tc_pkg::OFS_STATUS, 32'h4);
    // boundary reload keeps terminal count; step acts as a pulse
    wr(tc_pkg::OFS_MODE, mw(0, 0, 1, 4'h1, 0, tc_pkg::G_NONE));
    wr(tc_pkg::OFS_LOAD, 32'h1);
    cmd(tc_pkg::C_CLR_TOG);
    cmd(tc_pkg::C_LOAD_ARM);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_STATUS, 32'h3);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_STATUS, 32'h7);
    cmd(tc_pkg::C_STEP);
    rd(tc_pkg::OFS_STATUS, 32'h3);
    cmd(tc_pkg::C_DISARM);
    rd(tc_pkg::OFS_STATUS, 32'h3);
    wr(tc_pkg::OFS_LOAD, 32'h5);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_COUNT, 32'h5);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_STATUS, 32'h0);
    // load in the cycle before terminal count, then during it
    wr(tc_pkg::OFS_LOAD, 32'h4);
    cmd(tc_pkg::C_LOAD_ARM);
    i_tc_pins_model.pulse(0, 3);
    cmd(tc_pkg::C_LOAD);
    rd(tc_pkg::OFS_STATUS, 32'h3);
    rd(tc_pkg::OFS_COUNT, 32'h4);
    cmd(tc_pkg::C_LOAD);
    rd(tc_pkg::OFS_STATUS, 32'h5);
    // binary and bcd up counting across a digit boundary
    for (i = 0; i < 2; i++) begin
      cmd(tc_pkg::C_DISARM);
      wr(tc_pkg::OFS_MODE, mw(1, i[0], 1, 4'h1, 0, tc_pkg::G_NONE));
      wr(tc_pkg::OFS_LOAD, 32'h9);
      cmd(tc_pkg::C_LOAD_ARM);
      i_tc_pins_model.pulse(0, 1);
      rd(tc_pkg::OFS_COUNT, (i == 1) ? 32'h10 : 32'hA);
    end
    // falling-edge polarity counts only on the falling edge
    cmd(tc_pkg::C_DISARM);
    wr(tc_pkg::OFS_MODE, mw(0, 0, 1, 4'h1, 1, tc_pkg::G_NONE));
    wr(tc_pkg::OFS_LOAD, 32'h5);
    cmd(tc_pkg::C_LOAD_ARM);
    i_tc_pins_model.drive(0, 1'b1);
    rd(tc_pkg::OFS_COUNT, 32'h5);
    i_tc_pins_model.drive(0, 1'b0);
    rd(tc_pkg::OFS_COUNT, 32'h4);
    // own-gate level gating, both polarities, second source pin
    for (i = 0; i < 2; i++) begin
      cmd(tc_pkg::C_DISARM);
      wr(tc_pkg::OFS_MODE, mw(0, 0, 1, 4'h2, 0, tc_pkg::G_OWN_HIGH + 3'(i)));
      wr(tc_pkg::OFS_LOAD, 32'h5);
      cmd(tc_pkg::C_LOAD_ARM);
      i_tc_pins_model.gate(0, i[0]);
      i_tc_pins_model.pulse(1, 1);
      rd(tc_pkg::OFS_COUNT, 32'h5);
      i_tc_pins_model.gate(0, ~i[0]);
      i_tc_pins_model.pulse(1, 1);
      rd(tc_pkg::OFS_COUNT, 32'h4);
    end
    // level-gated retrigger: gate edge saves count, step then reloads
    cmd(tc_pkg::C_DISARM);
    wr(tc_pkg::OFS_MODE, mw(0, 0, 1, 4'h1, 0, tc_pkg::G_OWN_HIGH)
       | (32'h1 << tc_pkg::M_SPECIAL));
    wr(tc_pkg::OFS_LOAD, 32'h8);
    cmd(tc_pkg::C_LOAD_ARM);
    cmd(tc_pkg::C_STEP);
    i_tc_pins_model.gate(0, 1'b1);
    rd(tc_pkg::OFS_STATUS, 32'hD);
    rd(tc_pkg::OFS_HOLD, 32'h7);
    cmd(tc_pkg::C_STEP);
    rd(tc_pkg::OFS_COUNT, 32'h8);
    i_tc_pins_model.pulse(0, 2);
    rd(tc_pkg::OFS_COUNT, 32'h6);
    // edge gating with alternating reload: hold first, then load, then stop
    cmd(tc_pkg::C_DISARM);
    wr(tc_pkg::OFS_MODE, mw(0, 0, 0, 4'h1, 0, tc_pkg::G_EDGE_RISE)
       | (32'h1 << tc_pkg::M_RELOAD));
    wr(tc_pkg::OFS_LOAD, 32'h2);
    wr(tc_pkg::OFS_HOLD, 32'h3);
    i_tc_pins_model.gate(0, 1'b0);
    cmd(tc_pkg::C_LOAD_ARM);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_COUNT, 32'h3);
    i_tc_pins_model.gate(0, 1'b1);
    i_tc_pins_model.pulse(0, 3);
    rd(tc_pkg::OFS_STATUS, 32'h17);
    rd(tc_pkg::OFS_COUNT, 32'h3);
    i_tc_pins_model.pulse(0, 3);
    rd(tc_pkg::OFS_COUNT, 32'h2);
    i_tc_pins_model.pulse(0, 1);
    rd(tc_pkg::OFS_STATUS, 32'h4);
    // ungated special bit: gate high reloads hold, gate low reloads load
    wr(tc_pkg::OFS_MODE, mw(0, 0, 1, 4'h1, 0, tc_pkg::G_NONE)
       | (32'h1 << tc_pkg::M_SPECIAL));
    wr(tc_pkg::OFS_LOAD, 32'h6);
    cmd(tc_pkg::C_LOAD);
    rd(tc_pkg::OFS_COUNT, 32'h3);
    cmd(tc_pkg::C_LOAD);
    i_tc_pins_model.gate(0, 1'b0);
    cmd(tc_pkg::C_LOAD);
    rd(tc_pkg::OFS_COUNT, 32'h6);
    // a command written while the clock enable is low is lost
    clk_en <= 1'b0;
    cmd(tc_pkg::C_LOAD_ARM);
    clk_en <= 1'b1;
    rd(tc_pkg::OFS_STATUS, 32'h0);
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule : counter_tc_gating_control_tb_top
`default_nettype wire
